// ==== pkg/sep_pkg.sv ====
// Shared constants of the serial EEPROM command and protection block
package sep_pkg;

    // =========================================================
    // Opcode layout: upper nibble zero, bit 3 ignored
    localparam logic [3:0] OP_UPPER = 4'h0;
    localparam logic [2:0] OPL_SET_WEL = 3'h6;
    localparam logic [2:0] OPL_CLR_WEL = 3'h4;
    localparam logic [2:0] OPL_RD_STATUS = 3'h5;
    localparam logic [2:0] OPL_WR_STATUS = 3'h1;
    localparam logic [2:0] OPL_RD_ARRAY = 3'h3;
    localparam logic [2:0] OPL_WR_ARRAY = 3'h2;

    // =========================================================
    // Status register field positions and values
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_WEL_BIT = 1;
    localparam int ST_BPL_BIT = 2;
    localparam int ST_BPH_BIT = 3;
    localparam int ST_PE_BIT = 7;
    localparam logic [7:0] STATUS_BUSY_VALUE = 8'hff;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [1:0] BP_NONE = 2'h0;
    localparam logic [1:0] BP_QUARTER = 2'h1;
    localparam logic [1:0] BP_HALF = 2'h2;
    localparam logic [1:0] BP_ALL = 2'h3;
    localparam logic [1:0] NV_BP_RESET = 2'h0;
    localparam logic NV_PE_RESET = 1'b0;

    // =========================================================
    // Frame bit counts (value of the counter at the last bit of a byte)
    localparam logic [5:0] BIT_FRAME_FIRST = 6'h00;
    localparam logic [5:0] BIT_OPCODE_LAST = 6'h07;
    localparam logic [5:0] BIT_BYTE1_LAST = 6'h0f;
    localparam logic [5:0] BIT_BYTE2_LAST = 6'h17;
    localparam logic [5:0] BIT_BYTE3_LAST = 6'h1f;
    localparam logic [5:0] BIT_CNT_MAX = 6'h20;
    localparam int ADDR_W = 16;

    // =========================================================
    // Self-timed write cycle
    localparam int T_WC_MS = 5;
    localparam int CORE_CLK_KHZ = 200000;
    localparam int WC_CYCLES = T_WC_MS * CORE_CLK_KHZ;

    typedef enum logic [0:0] {
        SEP_IDLE = 1'b0,
        SEP_BUSY = 1'b1
    } sep_mode_type;

    // Recognised low opcode bits
    function automatic logic sep_op_known(input logic [2:0] c);
        return (c == OPL_SET_WEL) || (c == OPL_CLR_WEL) || (c == OPL_RD_STATUS) ||
               (c == OPL_WR_STATUS) || (c == OPL_RD_ARRAY) || (c == OPL_WR_ARRAY);
    endfunction

endpackage

// ==== pkg/sep_link_if.sv ====
// Signals between the core-clock command logic and the serial-clock front end
`timescale 1ns/1ps
interface sep_link_if;
    logic link_rst;
    logic [7:0] stat_hold;
    logic stat_req;
    logic stat_ack;
    logic op_seq;
    logic [2:0] op_code;
    logic [15:0] addr;
    logic [7:0] data;
    logic data_ok;
    logic addr_ok;
    logic so;
    logic so_oe;

    modport core (
        output link_rst, stat_hold, stat_req,
        input stat_ack, op_seq, op_code, addr, data, data_ok, addr_ok, so, so_oe
    );
    modport link (
        input link_rst, stat_hold, stat_req,
        output stat_ack, op_seq, op_code, addr, data, data_ok, addr_ok, so, so_oe
    );
endinterface

// ==== logic/sep_spi_link.sv ====
// Serial-clock front end: bit capture, opcode decode, status shift-out
`timescale 1ns/1ps
module sep_spi_link (
    input wire logic i_sclk,
    input wire logic i_cs_n,
    input wire logic i_si,
    sep_link_if.link lnk
);

    typedef struct packed {
        logic [5:0] cnt;
        logic [6:0] sh;
        logic dead;
        logic rd_stat;
    } sep_frame_type;

    typedef struct packed {
        logic seq;
        logic [2:0] op;
        logic [15:0] addr;
        logic [7:0] data;
        logic data_ok;
        logic addr_ok;
        logic req_s1;
        logic req_s2;
        logic ack;
        logic [7:0] stat;
    } sep_rec_type;

    typedef struct packed {
        logic [2:0] pos;
        logic [6:0] sh;
        logic so;
        logic oe;
    } sep_out_type;

    sep_frame_type fr, next_fr;
    sep_rec_type rc, next_rc;
    sep_out_type ou, next_ou;
    logic [7:0] byte_in;
    logic frame_rst;

    // Frame state clears while chip select is high
    assign frame_rst = i_cs_n | lnk.link_rst;
    assign byte_in = {fr.sh, i_si};

    // =========================================================
    // Next-state logic
    always_comb begin
        next_fr = fr;
        next_rc = rc;
        next_ou = ou;
        // MSb first shift in
        next_fr.sh = byte_in[6:0]; // RULE2
        if (fr.cnt != sep_pkg::BIT_CNT_MAX) begin
            next_fr.cnt = fr.cnt + 6'h01;
        end
        // Status word handshake from core
        next_rc.req_s1 = lnk.stat_req;
        next_rc.req_s2 = rc.req_s1;
        if (rc.req_s2 != rc.ack) begin
            next_rc.ack = rc.req_s2;
            next_rc.stat = lnk.stat_hold;
        end
        // Field capture, stopped after an unknown opcode
        if (!fr.dead) begin // RULE4
            case (fr.cnt)
                sep_pkg::BIT_FRAME_FIRST: begin
                    next_rc.data_ok = 1'b0;
                    next_rc.addr_ok = 1'b0;
                end
                sep_pkg::BIT_OPCODE_LAST: begin
                    // Eighth bit completes the instruction byte
                    if (byte_in[7:4] == sep_pkg::OP_UPPER && sep_pkg::sep_op_known(byte_in[2:0])) begin // RULE3
                        next_rc.op = byte_in[2:0];
                        next_rc.seq = ~rc.seq;
                        next_fr.rd_stat = (byte_in[2:0] == sep_pkg::OPL_RD_STATUS); // RULE7
                    end else begin
                        next_fr.dead = 1'b1; // RULE4
                    end
                end
                sep_pkg::BIT_BYTE1_LAST: begin
                    if (rc.op == sep_pkg::OPL_WR_STATUS) begin
                        next_rc.data = byte_in; // RULE7
                        next_rc.data_ok = 1'b1;
                    end else begin
                        next_rc.addr[15:8] = byte_in;
                    end
                end
                sep_pkg::BIT_BYTE2_LAST: begin
                    if (rc.op != sep_pkg::OPL_WR_STATUS) begin
                        next_rc.addr[7:0] = byte_in;
                        next_rc.addr_ok = 1'b1;
                    end
                end
                sep_pkg::BIT_BYTE3_LAST: begin
                    if (rc.op == sep_pkg::OPL_WR_ARRAY) begin
                        next_rc.data = byte_in; // RULE8
                        next_rc.data_ok = 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end
        // Status byte out on falling edges, repeated while selected
        if (fr.rd_stat) begin
            if (ou.pos == 3'h0) begin
                next_ou.so = rc.stat[7]; // RULE2
                next_ou.sh = rc.stat[6:0];
            end else begin
                next_ou.so = ou.sh[6];
                next_ou.sh = {ou.sh[5:0], 1'b0};
            end
            next_ou.pos = ou.pos + 3'h1;
            next_ou.oe = 1'b1;
        end
    end

    // =========================================================
    // Registers: frame and output clear on deselect, record survives
    always_ff @(posedge i_sclk or posedge frame_rst) begin // RULE1
        if (frame_rst) begin
            fr <= '0; // RULE25
        end else begin
            fr <= next_fr;
        end
    end

    always_ff @(posedge i_sclk or posedge lnk.link_rst) begin
        if (lnk.link_rst) begin
            rc <= '0;
        end else begin
            rc <= next_rc;
        end
    end

    always_ff @(negedge i_sclk or posedge frame_rst) begin
        if (frame_rst) begin
            ou <= '0;
        end else begin
            ou <= next_ou;
        end
    end

    assign lnk.stat_ack = rc.ack;
    assign lnk.op_seq = rc.seq;
    assign lnk.op_code = rc.op;
    assign lnk.addr = rc.addr;
    assign lnk.data = rc.data;
    assign lnk.data_ok = rc.data_ok;
    assign lnk.addr_ok = rc.addr_ok;
    assign lnk.so = ou.so;
    assign lnk.so_oe = ou.oe;

endmodule // sep_spi_link

// ==== logic/sep_eeprom_cmd.sv ====
// Command interpreter and write protection of a serial EEPROM
//
// Notes on behaviour
// RULE1 - Device is client; serial clock only input
// RULE2 - Chip select fall starts; all bits MSb first
// RULE3 - First byte goes to 8-bit instruction register
// RULE4 - Unknown opcode: no capture, output stays off
// RULE5 - Opcode 0000x110 sets write-enable latch
// RULE6 - Opcode 0000x100 clears write-enable latch
// RULE7 - 0000x101 reads status, 0000x001 writes status
// RULE8 - 0000x011 array read, 0000x010 array write
// RULE9 - Latch clear at power-up; host enables first
// RULE10 - Latch clear works whatever the protect pin
// RULE11 - Status bit 0 is busy flag
// RULE12 - Status bit 1 mirrors write-enable latch
// RULE13 - Bit 7 pin enable, bits 3:2 protect
// RULE14 - Bits 6:4 zero; all ones while busy
// RULE15 - Code 00 none, 01 top quarter
// RULE16 - Code 10 upper half, 11 all; readable
// RULE17 - Protect bits nonvolatile, need latch, self-timed
// RULE18 - Hardware protect when pin low and enabled
// RULE19 - No hardware protect if pin high/disabled
// RULE20 - Hardware protect blocks status and protected writes
// RULE21 - Pin enable not clearable while pin low
// RULE22 - While busy ignore all but status read
// RULE23 - Write cycle end clears write-enable latch
// RULE24 - Write ignored when latch clear
// RULE25 - Short frame abandoned without state change
`timescale 1ns/1ps
module sep_eeprom_cmd #(
    parameter int WC_CYCLES = sep_pkg::WC_CYCLES,
    parameter int ADDR_BITS = 13
) (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_sclk,
    input wire logic i_cs_n,
    input wire logic i_si,
    input wire logic i_wp_n,
    output logic o_so,
    output logic o_so_oe,
    output logic [7:0] o_status,
    output logic o_busy,
    output logic o_write_enabled,
    output logic o_hw_protect,
    output logic o_wr_strobe,
    output logic o_rd_strobe,
    output logic [15:0] o_mem_addr,
    output logic [7:0] o_mem_data
);

    // =========================================================
    // Derived widths
    localparam int WC_W = $clog2(WC_CYCLES + 1);
    localparam logic [WC_W-1:0] WC_LAST = WC_W'(WC_CYCLES - 1);

    // =========================================================
    // State of the core-clock side
    typedef struct packed {
        sep_pkg::sep_mode_type mode;
        logic link_rst;
        logic cs_s1;
        logic cs_s2;
        logic cs_s3;
        logic wp_s1;
        logic wp_s2;
        logic ack_s1;
        logic ack_s2;
        logic seen_seq;
        logic wel;
        logic [1:0] bp;
        logic pe;
        logic [1:0] pend_bp;
        logic pend_pe;
        logic pend_status;
        logic [WC_W-1:0] wc_cnt;
        logic [7:0] stat;
        logic [7:0] hold;
        logic req;
        logic wr_stb;
        logic rd_stb;
        logic [15:0] addr;
        logic [7:0] data;
    } sep_core_type;

    localparam sep_core_type SEP_CORE_RESET = '{
        mode: sep_pkg::SEP_IDLE,
        link_rst: 1'b1,
        cs_s1: 1'b1,
        cs_s2: 1'b1,
        cs_s3: 1'b1,
        wp_s1: 1'b1,
        wp_s2: 1'b1,
        ack_s1: 1'b0,
        ack_s2: 1'b0,
        seen_seq: 1'b0,
        wel: 1'b0,
        bp: sep_pkg::NV_BP_RESET,
        pe: sep_pkg::NV_PE_RESET,
        pend_bp: sep_pkg::NV_BP_RESET,
        pend_pe: sep_pkg::NV_PE_RESET,
        pend_status: 1'b0,
        wc_cnt: '0,
        stat: sep_pkg::STATUS_RESET,
        hold: sep_pkg::STATUS_RESET,
        req: 1'b0,
        wr_stb: 1'b0,
        rd_stb: 1'b0,
        addr: 16'h0000,
        data: 8'h00
    };

    sep_core_type st, next_st;
    sep_link_if lnk();

    logic cs_rise;
    logic new_cmd;
    logic hw_prot;
    logic addr_prot;
    logic [7:0] status_now;
    logic [ADDR_BITS-1:0] dev_addr;

    // =========================================================
    // Serial-clock front end
    sep_spi_link u_link (
        .i_sclk(i_sclk),
        .i_cs_n(i_cs_n),
        .i_si(i_si),
        .lnk(lnk.link)
    );

    // Handshake toward the front end
    assign lnk.link_rst = st.link_rst;
    assign lnk.stat_hold = st.hold;
    assign lnk.stat_req = st.req;

    // =========================================================
    // Frame end detection
    // Record in the front end is static once chip select is high,
    // so it is read directly after the synchronised rising edge.
    assign cs_rise = st.cs_s2 & ~st.cs_s3;
    // A frame counts only if a whole known opcode toggled the sequence bit
    assign new_cmd = cs_rise & (lnk.op_seq != st.seen_seq); // RULE25

    // =========================================================
    // Protection decisions
    // Hardware protect: pin low and enable bit set, nothing else
    assign hw_prot = st.pe & ~st.wp_s2; // RULE18 RULE19

    // Only the implemented address bits count
    assign dev_addr = lnk.addr[ADDR_BITS-1:0];

    // Block-protect decode by segment of the array
    always_comb begin
        case (st.bp)
            sep_pkg::BP_NONE: addr_prot = 1'b0; // RULE15
            sep_pkg::BP_QUARTER: addr_prot = (dev_addr[ADDR_BITS-1 -: 2] == 2'h3); // RULE15
            sep_pkg::BP_HALF: addr_prot = dev_addr[ADDR_BITS-1]; // RULE16
            sep_pkg::BP_ALL: addr_prot = 1'b1; // RULE16
            default: addr_prot = 1'b1;
        endcase
    end

    // =========================================================
    // Status image as software sees it
    always_comb begin
        status_now = 8'h00; // RULE14
        status_now[sep_pkg::ST_PE_BIT] = st.pe; // RULE13
        status_now[sep_pkg::ST_BPH_BIT] = st.bp[1]; // RULE13
        status_now[sep_pkg::ST_BPL_BIT] = st.bp[0]; // RULE13
        status_now[sep_pkg::ST_WEL_BIT] = st.wel; // RULE12
        status_now[sep_pkg::ST_BUSY_BIT] = 1'b0; // RULE11
        if (st.mode == sep_pkg::SEP_BUSY) begin
            status_now = sep_pkg::STATUS_BUSY_VALUE; // RULE11 RULE14
        end
    end

    // =========================================================
    // Next-state logic
    always_comb begin
        next_st = st;
        // Front end leaves reset one cycle after the core
        next_st.link_rst = 1'b0;
        // Pin synchronisers, two flops each, plus a third chip select flop for edge detection
        next_st.cs_s1 = i_cs_n;
        next_st.cs_s2 = st.cs_s1;
        next_st.cs_s3 = st.cs_s2;
        next_st.wp_s1 = i_wp_n;
        next_st.wp_s2 = st.wp_s1;
        next_st.ack_s1 = lnk.stat_ack;
        next_st.ack_s2 = st.ack_s1;
        // Strobes last one cycle
        next_st.wr_stb = 1'b0;
        next_st.rd_stb = 1'b0;
        next_st.stat = status_now;

        // Publish status to the front end when the last word was taken
        if (st.ack_s2 == st.req && st.hold != st.stat) begin
            next_st.hold = st.stat;
            next_st.req = ~st.req;
        end

        // Every finished frame is consumed, executed or not
        if (new_cmd) begin
            next_st.seen_seq = lnk.op_seq;
        end

        case (st.mode)
            sep_pkg::SEP_IDLE: begin
                if (new_cmd) begin
                    case (lnk.op_code)
                        sep_pkg::OPL_SET_WEL: begin
                            next_st.wel = 1'b1; // RULE5
                        end
                        sep_pkg::OPL_CLR_WEL: begin
                            // Independent of the protect pin
                            next_st.wel = 1'b0; // RULE6 RULE10
                        end
                        sep_pkg::OPL_WR_STATUS: begin
                            // Needs latch, a full byte and no hardware protect
                            if (st.wel && lnk.data_ok && !hw_prot) begin // RULE17 RULE20 RULE21 RULE24
                                next_st.pend_bp = lnk.data[sep_pkg::ST_BPH_BIT:sep_pkg::ST_BPL_BIT];
                                next_st.pend_pe = lnk.data[sep_pkg::ST_PE_BIT];
                                next_st.pend_status = 1'b1;
                                next_st.mode = sep_pkg::SEP_BUSY; // RULE17
                                next_st.wc_cnt = '0;
                            end
                        end
                        sep_pkg::OPL_WR_ARRAY: begin
                            // Protected segments stay read-only
                            if (st.wel && lnk.addr_ok && lnk.data_ok && !addr_prot) begin // RULE8 RULE16 RULE20 RULE24
                                next_st.wr_stb = 1'b1;
                                next_st.addr = lnk.addr;
                                next_st.data = lnk.data;
                                next_st.mode = sep_pkg::SEP_BUSY;
                                next_st.wc_cnt = '0;
                            end
                        end
                        sep_pkg::OPL_RD_ARRAY: begin
                            // Reads ignore protection
                            if (lnk.addr_ok) begin // RULE8 RULE16
                                next_st.rd_stb = 1'b1;
                                next_st.addr = lnk.addr;
                            end
                        end
                        default: begin
                        end
                    endcase
                end
            end
            sep_pkg::SEP_BUSY: begin
                // Commands arriving now are dropped; status reads run in the front end
                if (st.wc_cnt == WC_LAST) begin // RULE22
                    next_st.mode = sep_pkg::SEP_IDLE;
                    next_st.wel = 1'b0; // RULE23
                    if (st.pend_status) begin
                        next_st.bp = st.pend_bp; // RULE17
                        next_st.pe = st.pend_pe;
                        next_st.pend_status = 1'b0;
                    end
                end else begin
                    next_st.wc_cnt = st.wc_cnt + 1'b1;
                end
            end
            default: begin
                next_st.mode = sep_pkg::SEP_IDLE;
            end
        endcase
    end

    // =========================================================
    // State register, write latch cleared by reset
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            st <= SEP_CORE_RESET; // RULE9
        end else begin
            st <= next_st;
        end
    end

    // =========================================================
    // Outputs
    assign o_so = lnk.so;
    assign o_so_oe = lnk.so_oe; // RULE4
    assign o_status = st.stat;
    assign o_busy = (st.mode == sep_pkg::SEP_BUSY);
    assign o_write_enabled = st.wel;
    assign o_hw_protect = st.pe & ~st.wp_s2;
    assign o_wr_strobe = st.wr_stb;
    assign o_rd_strobe = st.rd_stb;
    assign o_mem_addr = st.addr;
    assign o_mem_data = st.data;

endmodule // sep_eeprom_cmd

// ==== sim/sep_eeprom_cmd_monitor.sv ====
// Port-level checks of the EEPROM command and protection block
`timescale 1ns/1ps
module sep_eeprom_cmd_monitor #(
    parameter int WC_CYCLES = 20
) (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_sclk,
    input wire logic i_cs_n,
    input wire logic i_si,
    input wire logic i_wp_n,
    input wire logic o_so,
    input wire logic o_so_oe,
    input wire logic [7:0] o_status,
    input wire logic o_busy,
    input wire logic o_write_enabled,
    input wire logic o_hw_protect,
    input wire logic o_wr_strobe,
    input wire logic o_rd_strobe,
    input wire logic [15:0] o_mem_addr,
    input wire logic [7:0] o_mem_data
);
    logic [31:0] busy_cnt;
    // =========================================================
    // Busy length counter
    always_ff @(posedge i_core_clk) begin
        if (i_rst || !o_busy) busy_cnt <= 32'h00000000;
        else busy_cnt <= busy_cnt + 32'h00000001;
    end
    // =========================================================
    // Checks
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    a_oe_deselect: assert property (i_cs_n |-> !o_so_oe)
        else $error("output on while deselected");
    a_busy_all_ones: assert property (o_busy && $past(o_busy) |-> o_status == 8'hff)
        else $error("status not all ones while busy");
    a_idle_zero_bits: assert property (!o_busy && !$past(o_busy) |-> o_status[6:4] == 3'h0 && !o_status[0])
        else $error("unused or busy bits set while idle");
    a_latch_mirror: assert property (!o_busy && !$past(o_busy) && $stable(o_write_enabled)
        |-> o_status[1] == o_write_enabled) else $error("status bit 1 differs from latch");
    a_pin_enable_set: assert property (o_hw_protect && !o_busy && !$past(o_busy) |-> o_status[7])
        else $error("hw protect without pin enable");
    a_pin_high_off: assert property ($past(i_wp_n, 1) && $past(i_wp_n, 2) && $past(i_wp_n, 3)
        && $past(i_wp_n, 4) |-> !o_hw_protect) else $error("hw protect with pin high");
    a_write_needs_latch: assert property ($rose(o_busy) |-> $past(o_write_enabled))
        else $error("write cycle without latch");
    a_latch_end_clear: assert property ($fell(o_busy) |-> ##[0:1] !o_write_enabled)
        else $error("latch kept after write cycle");
    a_busy_ignores: assert property (o_busy && $past(o_busy) |-> !o_wr_strobe && !o_rd_strobe)
        else $error("command taken while busy");
    a_cycle_length: assert property ($fell(o_busy) |-> busy_cnt >= WC_CYCLES - 1 && busy_cnt <= WC_CYCLES + 1)
        else $error("write cycle length wrong");
endmodule // sep_eeprom_cmd_monitor

bind sep_eeprom_cmd sep_eeprom_cmd_monitor #(.WC_CYCLES(WC_CYCLES)) mon (.i_core_clk, .i_rst, .i_sclk, .i_cs_n,
    .i_si, .i_wp_n, .o_so, .o_so_oe, .o_status, .o_busy, .o_write_enabled, .o_hw_protect, .o_wr_strobe,
    .o_rd_strobe, .o_mem_addr, .o_mem_data);

// ==== sim/sep_spi_host.sv ====
// Mode 0 serial host model driving clock, select and data in
`timescale 1ns/1ps
module sep_spi_host (
    output logic o_sclk,
    output logic o_cs_n,
    output logic o_si,
    input wire logic i_so,
    input wire logic i_so_oe
);
    // =========================================================
    // Idle bus: clock parked low, device deselected
    initial begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_si = 1'b0;
    end
    // One frame, bits left aligned; rx keeps the last eight bits
    task automatic xfer(input logic [31:0] tx, input int nbits, output logic [7:0] rx, output logic oe);
        rx = 8'h00;
        oe = 1'b0;
        #1.3; // Off the core clock grid
        o_cs_n = 1'b0;
        #15;
        for (int i = 0; i < nbits; i++) begin
            o_si = tx[31 - i];
            #15 o_sclk = 1'b1;
            rx = {rx[6:0], i_so_oe ? i_so : ~i_so}; // Undriven line reads inverted
            oe = oe | i_so_oe;
            #15 o_sclk = 1'b0;
        end
        #15 o_cs_n = 1'b1;
        o_si = ~o_si;
        #60;
    endtask
endmodule // sep_spi_host

// ==== sim/tb_spi_eeprom_cmd_protect.sv ====
// Self-checking bench of the EEPROM command and protection block
`timescale 1ns/1ps
module tb_spi_eeprom_cmd_protect;
    logic i_core_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_wp_n = 1'b1;
    logic sclk, cs_n, si, so, so_oe, busy, wel, hwp, wrs, rds, oe_seen;
    logic [7:0] status, mdata, rx;
    logic [15:0] maddr;
    logic [15:0] lo_prot [4] = '{16'h2000, 16'h1800, 16'h1000, 16'h0000};
    int n_errors = 0;
    int n_compared = 0;
    int cycles = 0;
    int n_wr = 0;
    int n_rd = 0;
    int cnt0;

    sep_eeprom_cmd #(.WC_CYCLES(400)) dut (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_sclk(sclk), .i_cs_n(cs_n),
        .i_si(si), .i_wp_n(i_wp_n), .o_so(so), .o_so_oe(so_oe), .o_status(status), .o_busy(busy),
        .o_write_enabled(wel), .o_hw_protect(hwp), .o_wr_strobe(wrs), .o_rd_strobe(rds), .o_mem_addr(maddr),
        .o_mem_data(mdata));
    sep_spi_host host (.o_sclk(sclk), .o_cs_n(cs_n), .o_si(si), .i_so(so), .i_so_oe(so_oe));

    // =========================================================
    // Clock, strobe counts and cycle ceiling
    always #2.5 i_core_clk = ~i_core_clk;
    always @(negedge i_core_clk) begin
        cycles++;
        n_wr += int'(wrs === 1'b1);
        n_rd += int'(rds === 1'b1);
        if (cycles == 40000) begin
            n_errors++;
            tally_and_finish();
        end
    end

    // =========================================================
    // Tasks
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic cmd(input logic [31:0] tx, input int nbits);
        host.xfer(tx, nbits, rx, oe_seen);
        repeat (8) @(negedge i_core_clk);
    endtask
    task automatic read_status_cmd(input logic [7:0] exp);
        cmd(32'h05000000, 16);
        check("status read", {7'h00, oe_seen, rx}, {7'h00, 1'b1, exp});
    endtask
    task automatic wait_idle;
        for (int k = 0; k < 1000 && busy !== 1'b0; k++) @(negedge i_core_clk);
        check("busy end", 16'(busy), 16'h0000);
    endtask
    task automatic wr_array(input logic [15:0] a, input logic [7:0] d, input logic ok);
        cnt0 = n_wr;
        cmd({8'h02, a, d}, 32);
        check("write taken", 16'(n_wr - cnt0), 16'(ok));
        if (ok) check("write word", {maddr[7:0], mdata}, {a[7:0], d});
    endtask
    task automatic tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // =========================================================
    // Main sequence
    initial begin
        repeat (5) @(negedge i_core_clk);
        i_rst = 1'b0;
        repeat (4) @(negedge i_core_clk);
        check("status reset", 16'(status), 16'h0000);
        read_status_cmd(8'h00);
        for (int i = 0; i < 2; i++) begin
            cmd({4'h0, i[0], 3'h6, 24'h000000}, 8);
            check("latch set", 16'(wel), 16'h0001);
            read_status_cmd(8'h02);
            cmd({4'h0, i[0], 3'h4, 24'h000000}, 8);
            check("latch clear", 16'(wel), 16'h0000);
        end
        cmd(32'h07000000, 16);
        check("unknown oe", 16'(oe_seen), 16'h0000);
        cmd(32'h86000000, 16);
        cmd(32'h06000000, 5);
        check("latch idle", 16'(wel), 16'h0000);
        wr_array(16'h0123, 8'h5a, 1'b0);
        cnt0 = n_rd;
        cmd(32'h03123400, 24);
        check("read taken", 16'(n_rd - cnt0), 16'h0001);
        check("read addr", maddr, 16'h1234);
        // Status write with commands sent during the cycle
        cmd(32'h06000000, 8);
        cmd(32'h018c0000, 16);
        check("busy", 16'(busy), 16'h0001);
        read_status_cmd(8'hff);
        cmd(32'h04000000, 8);
        check("busy ignores", 16'(wel), 16'h0001);
        wait_idle();
        check("latch after", 16'(wel), 16'h0000);
        read_status_cmd(8'h8c);
        // Pin low with pin enable set
        i_wp_n = 1'b0;
        repeat (6) @(negedge i_core_clk);
        check("hw protect", 16'(hwp), 16'h0001);
        cmd(32'h06000000, 8);
        cmd(32'h01000000, 16);
        check("status refused", 16'(busy), 16'h0000);
        read_status_cmd(8'h8e);
        wr_array(16'h0010, 8'h11, 1'b0);
        cmd(32'h04000000, 8);
        check("clear under pin", 16'(wel), 16'h0000);
        i_wp_n = 1'b1;
        repeat (6) @(negedge i_core_clk);
        check("hw protect off", 16'(hwp), 16'h0000);
        // Each protect level: last open address taken unless all guarded, first guarded refused unless none guarded
        for (int k = 0; k < 4; k++) begin
            cmd(32'h06000000, 8);
            cmd({8'h01, 4'h0, k[1:0], 2'h0, 16'h0000}, 16);
            wait_idle();
            read_status_cmd({4'h0, k[1:0], 2'h0});
            if (lo_prot[k] != 16'h0000) begin
                cmd(32'h06000000, 8);
                wr_array(lo_prot[k] - 16'h0001, 8'ha5, 1'b1);
                wait_idle();
            end
            if (lo_prot[k] != 16'h2000) begin
                cmd(32'h06000000, 8);
                wr_array(lo_prot[k], 8'h3c, 1'b0);
            end
        end
        tally_and_finish();
    end
endmodule // tb_spi_eeprom_cmd_protect
